// ===== src/tft_port_pkg.sv
/*
 * constants shared by both ends of the byte-wide display module port:
 * strobe timing, pin layout, index values, memory size and field positions.
 * assumes a single 20 MHz clock on both ends.
 */
package tft_port_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int WR_LOW_NS     = 250;
    localparam int RD_LOW_NS     = 600;
    localparam int GAP_NS        = 300;
    // least times, rounded up to whole cycles
    localparam int WR_LOW_CYC    = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_LOW_CYC    = (RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC       = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 5;

    localparam int BUS_W         = 8;
    localparam int WORD_W        = 16;
    localparam int LOWER_W       = 10;
    localparam int STRAP_W       = 4;
    localparam int SYNC_STAGES   = 3;
    localparam logic [3:0] MODE_8BIT_STRAPS = 4'h3;
    localparam logic [9:0] LOWER_TIE        = 10'h000;

    // synchroniser vector layout on the device end
    localparam int P_CS_N  = 0;
    localparam int P_RS    = 1;
    localparam int P_WR_N  = 2;
    localparam int P_RD_N  = 3;
    localparam int P_RST_N = 4;
    localparam int P_DATA  = 5;
    localparam int P_STRAP = P_DATA + BUS_W;
    localparam int PIN_W   = P_STRAP + STRAP_W;
    localparam logic [16:0] PIN_IDLE = 17'h0_001D;

    localparam int IDX_W = 7;
    localparam logic [6:0] IDX_CODE  = 7'h00;
    localparam logic [6:0] IDX_ENTRY = 7'h05;
    localparam logic [6:0] IDX_ADDR  = 7'h21;
    localparam logic [6:0] IDX_RAM   = 7'h22;
    localparam int DIR_BIT = 4;
    localparam logic [15:0] ENTRY_RST = 16'h0010;

    localparam int RAM_BYTES  = 46080;
    localparam int RAM_WORDS  = RAM_BYTES / 2;
    localparam int ADDR_W     = 15;
    localparam int PANEL_COLS = 128;
    localparam int PANEL_ROWS = 160;
    localparam int COL_W      = 7;
    localparam int ROW_W      = 8;

    localparam int RED_LSB = 11;
    localparam int RED_W   = 5;
    localparam int GRN_LSB = 5;
    localparam int GRN_W   = 6;
    localparam int BLU_LSB = 0;
    localparam int BLU_W   = 5;

    // host command word: {rs, read, data}
    localparam int CMD_W    = WORD_W + 2;
    localparam int CMD_RS   = WORD_W + 1;
    localparam int CMD_READ = WORD_W;
endpackage

// ===== src/tft_link_if.sv
/*
 * pin bundle between the host end and the display module end.
 * the shared data lanes are resolved here from the two output enables;
 * an undriven bus reads high, as a weak pull-up would make it.
 */
`timescale 1ns/1ps
`default_nettype none
interface tft_link_if;
    import tft_port_pkg::*;
    logic               cs_n;
    logic               rs;
    logic               wr_n;
    logic               rd_n;
    logic               panel_rst_n;
    logic [STRAP_W-1:0] straps;
    logic [LOWER_W-1:0] lower_lanes;
    logic [BUS_W-1:0]   host_d;
    logic               host_oe;
    logic [BUS_W-1:0]   dev_d;
    logic               dev_oe;
    logic [BUS_W-1:0]   bus;

    assign bus = host_oe ? host_d : (dev_oe ? dev_d : 8'hFF);

    modport device (
        input  cs_n, rs, wr_n, rd_n, panel_rst_n, straps, lower_lanes, bus,
        output dev_d, dev_oe
    );
    modport host (
        output cs_n, rs, wr_n, rd_n, panel_rst_n, straps, lower_lanes,
        output host_d, host_oe,
        input  bus
    );
endinterface
`default_nettype wire

// ===== src/tft_module_end.sv
/*
 * display module end of the byte-wide port: pin synchronisers, byte pairing,
 * index and command decode, display memory with address counter, raster scan.
 * assumes the host keeps each strobe low and high long enough for the
 * three-stage synchroniser, and holds data steady until after the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - act only while chip select is low
// - active low reset initialises display logic
// - select low index/status, high command register
// - capture written byte only under write strobe
// - drive read data only during read strobe
// - eight bit two-way bus, 80 style
// - byte mode only with straps low,low,high,high
// - host ties unused lower lanes to fixed level
// - host always sends index upper byte too
// - pixel is 5 red, 6 green, 5 blue
// - memory of 46080 bytes, 128x160 pixels
// - status upper byte holds current raster row
// - address steps by one per memory write
module tft_module_end
    import tft_port_pkg::*;
#(
    parameter logic [15:0] DEVICE_CODE = 16'hA5C3 // arbitrary value
) (
    input  wire logic           core_clk_in,
    input  wire logic           rstn_in,
    tft_link_if.device          link,
    output logic [ROW_W-1:0]    raster_row_out,
    output logic [RED_W-1:0]    red_out,
    output logic [GRN_W-1:0]    green_out,
    output logic [BLU_W-1:0]    blue_out,
    output logic [IDX_W-1:0]    index_out,
    output logic                mode_ok_out
);
    if (PANEL_COLS * PANEL_ROWS > RAM_WORDS) begin : g_bad_size
        $error("panel does not fit the display memory");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_r;
    logic [PIN_W-1:0] s2_r;
    logic [PIN_W-1:0] s3_r;
    logic [PIN_W-1:0] pin_r;
    logic [PIN_W-1:0] pin_nxt;
    logic [PIN_W-1:0] pin_prev_r;

    assign pin_raw = {link.straps, link.bus, link.panel_rst_n,
                      link.rd_n, link.wr_n, link.rs, link.cs_n};

    for (genvar i = 0; i < PIN_W; i++) begin : g_filt
        assign pin_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_r[i];
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            s1_r       <= PIN_IDLE;
            s2_r       <= PIN_IDLE;
            s3_r       <= PIN_IDLE;
            pin_r      <= PIN_IDLE;
            pin_prev_r <= PIN_IDLE;
        end else begin
            s1_r       <= pin_raw;
            s2_r       <= s1_r;
            s3_r       <= s2_r;
            pin_r      <= pin_nxt;
            pin_prev_r <= pin_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded pin events
    logic             mode_ok_r;
    logic             mode_ok_nxt;
    logic             sel;
    logic             wr_rise;
    logic             rd_fall;
    logic             rd_rise;
    logic             init;
    logic [BUS_W-1:0] din;

    assign init    = !rstn_in || !pin_r[P_RST_N];
    assign sel     = !pin_r[P_CS_N] && mode_ok_r;
    assign wr_rise = sel && pin_r[P_WR_N] && !pin_prev_r[P_WR_N];
    assign rd_fall = sel && !pin_r[P_RD_N] && pin_prev_r[P_RD_N];
    assign rd_rise = pin_r[P_RD_N] && !pin_prev_r[P_RD_N];
    assign din     = pin_r[P_DATA +: BUS_W];

    ////////////////////////////////////////////////////////////////////////
    // port state
    logic [BUS_W-1:0]  upper_r,   upper_nxt;
    logic              half_r,    half_nxt;
    logic [IDX_W-1:0]  index_r,   index_nxt;
    logic [WORD_W-1:0] entry_r,   entry_nxt;
    logic [ADDR_W-1:0] addr_r,    addr_nxt;
    logic [WORD_W-1:0] rword_r,   rword_nxt;
    logic [BUS_W-1:0]  dout_r,    dout_nxt;
    logic              oe_r,      oe_nxt;
    logic [2:0]        settle_r,  settle_nxt;
    logic [COL_W-1:0]  col_r,     col_nxt;
    logic [ROW_W-1:0]  row_r,     row_nxt;
    logic              ram_we;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] ram_q_r;
    logic [WORD_W-1:0] scan_q_r;
    logic [WORD_W-1:0] mem [RAM_WORDS];

    assign word = {upper_r, din};

    always_comb begin
        upper_nxt   = upper_r;
        half_nxt    = half_r;
        index_nxt   = index_r;
        entry_nxt   = entry_r;
        addr_nxt    = addr_r;
        rword_nxt   = rword_r;
        dout_nxt    = dout_r;
        oe_nxt      = oe_r;
        mode_ok_nxt = mode_ok_r;
        settle_nxt  = settle_r;
        ram_we      = 1'b0;
        if (settle_r != 3'(SYNC_STAGES + 2)) begin
            settle_nxt = settle_r + 1'b1;
        end
        // straps are caught once, when the synchroniser has refilled after
        // reset; before that the filter still shows idle straps of zero
        if (settle_r == 3'(SYNC_STAGES + 1)) begin
            mode_ok_nxt = (pin_r[P_STRAP +: STRAP_W] == MODE_8BIT_STRAPS);
        end
        if (pin_r[P_CS_N]) begin
            half_nxt = 1'b0;
            oe_nxt   = 1'b0;
        end else if (wr_rise) begin
            if (!half_r) begin
                upper_nxt = din;
                half_nxt  = 1'b1;
            end else begin
                half_nxt = 1'b0;
                if (!pin_r[P_RS]) begin
                    index_nxt = word[IDX_W-1:0];
                end else if (index_r == IDX_ENTRY) begin
                    entry_nxt = word;
                end else if (index_r == IDX_ADDR) begin
                    addr_nxt = word[ADDR_W-1:0];
                end else if (index_r == IDX_RAM) begin
                    ram_we = 1'b1;
                    if (entry_r[DIR_BIT]) begin
                        addr_nxt = (addr_r == ADDR_W'(RAM_WORDS - 1)) ? '0 : addr_r + 1'b1;
                    end else begin
                        addr_nxt = (addr_r == '0) ? ADDR_W'(RAM_WORDS - 1) : addr_r - 1'b1;
                    end
                end
            end
        end else if (rd_fall) begin
            oe_nxt = 1'b1;
            if (half_r) begin
                dout_nxt = rword_r[BUS_W-1:0];
            end else begin
                if (!pin_r[P_RS]) begin
                    rword_nxt = {row_r, 8'h00};
                end else if (index_r == IDX_CODE) begin
                    rword_nxt = DEVICE_CODE;
                end else if (index_r == IDX_ENTRY) begin
                    rword_nxt = entry_r;
                end else if (index_r == IDX_RAM) begin
                    rword_nxt = ram_q_r;
                end else begin
                    rword_nxt = 16'h0000;
                end
                dout_nxt = rword_nxt[WORD_W-1:BUS_W];
            end
        end else if (rd_rise && oe_r) begin
            oe_nxt   = 1'b0;
            half_nxt = !half_r;
        end
        // raster scan, one pixel per cycle
        col_nxt = col_r + 1'b1;
        row_nxt = row_r;
        if (col_r == COL_W'(PANEL_COLS - 1)) begin
            row_nxt = (row_r == ROW_W'(PANEL_ROWS - 1)) ? '0 : row_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (init) begin
            upper_r   <= 8'h00;
            half_r    <= 1'b0;
            index_r   <= 7'h00;
            entry_r   <= ENTRY_RST;
            addr_r    <= 15'h0000;
            rword_r   <= 16'h0000;
            dout_r    <= 8'h00;
            oe_r      <= 1'b0;
            mode_ok_r <= 1'b0;
            settle_r  <= 3'h0;
            col_r     <= 7'h00;
            row_r     <= 8'h00;
        end else begin
            upper_r   <= upper_nxt;
            half_r    <= half_nxt;
            index_r   <= index_nxt;
            entry_r   <= entry_nxt;
            addr_r    <= addr_nxt;
            rword_r   <= rword_nxt;
            dout_r    <= dout_nxt;
            oe_r      <= oe_nxt;
            mode_ok_r <= mode_ok_nxt;
            settle_r  <= settle_nxt;
            col_r     <= col_nxt;
            row_r     <= row_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // display memory: host write port, host read and scan read ports
    logic [ADDR_W-1:0] scan_addr;
    assign scan_addr = ADDR_W'({row_r, col_r});  // row * 128 + col

    always_ff @(posedge core_clk_in) begin
        if (ram_we) begin
            mem[addr_r] <= word;
        end
        ram_q_r  <= mem[addr_r];
        scan_q_r <= mem[scan_addr];
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    logic [ROW_W-1:0] row_out_r;
    always_ff @(posedge core_clk_in) begin
        if (init) begin
            row_out_r <= 8'h00;
        end else begin
            row_out_r <= row_r;
        end
    end

    assign link.dev_d     = dout_r;
    assign link.dev_oe    = oe_r;
    assign raster_row_out = row_out_r;
    assign red_out        = scan_q_r[RED_LSB +: RED_W];
    assign green_out      = scan_q_r[GRN_LSB +: GRN_W];
    assign blue_out       = scan_q_r[BLU_LSB +: BLU_W];
    assign index_out      = index_r;
    assign mode_ok_out    = mode_ok_r;
endmodule
`default_nettype wire

// ===== src/tft_host_end.sv
/*
 * host end of the byte-wide display module port, with its command fifo.
 * assumes the display module end answers reads within the read strobe
 * and that the user side keeps each command steady while valid and not ready.
 */
`timescale 1ns/1ps
`default_nettype none
module cmd_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("fifo depth must be a power of two of at least two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wp_r,  wp_nxt;
    logic [PW-1:0]    rp_r,  rp_nxt;
    logic [PW:0]      cnt_r, cnt_nxt;
    logic             full_r, empty_r;
    logic             push, pop;

    assign push = in_valid_in && !full_r;
    assign pop  = out_ready_in && !empty_r;

    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            wp_r    <= '0;
            rp_r    <= '0;
            cnt_r   <= '0;
            full_r  <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            wp_r    <= wp_nxt;
            rp_r    <= rp_nxt;
            cnt_r   <= cnt_nxt;
            full_r  <= (cnt_nxt == (PW+1)'(DEPTH));
            empty_r <= (cnt_nxt == '0);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[wp_r] <= in_data_in;
        end
    end

    assign in_ready_out  = !full_r;
    assign out_valid_out = !empty_r;
    assign out_data_out  = mem[rp_r];
endmodule

////////////////////////////////////////////////////////////////////////////
module tft_host_end
    import tft_port_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              core_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              cmd_valid_in,
    output logic                   cmd_ready_out,
    input  wire logic              cmd_rs_in,
    input  wire logic              cmd_read_in,
    input  wire logic [WORD_W-1:0] cmd_data_in,
    output logic                   rd_valid_out,
    output logic [WORD_W-1:0]      rd_data_out,
    tft_link_if.host               link
);
    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_GAP} hstate_type;

    logic             f_valid;
    logic             f_ready;
    logic [CMD_W-1:0] f_data;

    cmd_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) cmd_fifo_i (
        .core_clk_in   (core_clk_in),
        .rstn_in       (rstn_in),
        .in_valid_in   (cmd_valid_in),
        .in_ready_out  (cmd_ready_out),
        .in_data_in    ({cmd_rs_in, cmd_read_in, cmd_data_in}),
        .out_valid_out (f_valid),
        .out_ready_in  (f_ready),
        .out_data_out  (f_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // read data synchroniser: a change counts once stages two and three agree
    logic [BUS_W-1:0] s1_r, s2_r, s3_r, bus_r;
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            s1_r  <= 8'hFF;
            s2_r  <= 8'hFF;
            s3_r  <= 8'hFF;
            bus_r <= 8'hFF;
        end else begin
            s1_r  <= link.bus;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            bus_r <= (s2_r == s3_r) ? s3_r : bus_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    hstate_type        st_r,    st_nxt;
    logic [CNT_W-1:0]  cnt_r,   cnt_nxt;
    logic              byte_r,  byte_nxt;
    logic              rs_r,    rs_nxt;
    logic              read_r,  read_nxt;
    logic [WORD_W-1:0] word_r,  word_nxt;
    logic              cs_n_r,  cs_n_nxt;
    logic              wr_n_r,  wr_n_nxt;
    logic              rd_n_r,  rd_n_nxt;
    logic [BUS_W-1:0]  d_r,     d_nxt;
    logic              oe_r,    oe_nxt;
    logic              rdv_r,   rdv_nxt;
    logic              prst_r;

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r + 1'b1;
        byte_nxt = byte_r;
        rs_nxt   = rs_r;
        read_nxt = read_r;
        word_nxt = word_r;
        cs_n_nxt = cs_n_r;
        wr_n_nxt = wr_n_r;
        rd_n_nxt = rd_n_r;
        d_nxt    = d_r;
        oe_nxt   = oe_r;
        rdv_nxt  = 1'b0;
        f_ready  = 1'b0;
        case (st_r)
            H_IDLE: begin
                if (f_valid) begin
                    f_ready  = 1'b1;
                    rs_nxt   = f_data[CMD_RS];
                    read_nxt = f_data[CMD_READ];
                    word_nxt = f_data[WORD_W-1:0];
                    byte_nxt = 1'b0;
                    cs_n_nxt = 1'b0;
                    st_nxt   = H_SETUP;
                end
            end
            H_SETUP: begin
                cnt_nxt = '0;
                oe_nxt  = !read_r;
                // upper byte first; index writes always carry both bytes
                d_nxt   = byte_r ? word_r[BUS_W-1:0] : word_r[WORD_W-1:BUS_W];
                wr_n_nxt = read_r;
                rd_n_nxt = !read_r;
                st_nxt  = H_STROBE;
            end
            H_STROBE: begin
                if (cnt_r == CNT_W'((read_r ? RD_LOW_CYC : WR_LOW_CYC) - 1)) begin
                    wr_n_nxt = 1'b1;
                    rd_n_nxt = 1'b1;
                    cnt_nxt  = '0;
                    if (read_r) begin
                        word_nxt = byte_r ? {word_r[WORD_W-1:BUS_W], bus_r}
                                          : {bus_r, word_r[BUS_W-1:0]};
                    end
                    st_nxt = H_GAP;
                end
            end
            H_GAP: begin
                // data held through the gap so the module captures it cleanly
                if (cnt_r == CNT_W'(GAP_CYC - 1)) begin
                    oe_nxt = 1'b0;
                    if (!byte_r) begin
                        byte_nxt = 1'b1;
                        st_nxt   = H_SETUP;
                    end else begin
                        cs_n_nxt = 1'b1;
                        rdv_nxt  = read_r;
                        st_nxt   = H_IDLE;
                    end
                end
            end
            default: st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st_r   <= H_IDLE;
            cnt_r  <= '0;
            byte_r <= 1'b0;
            rs_r   <= 1'b0;
            read_r <= 1'b0;
            word_r <= 16'h0000;
            cs_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            d_r    <= 8'h00;
            oe_r   <= 1'b0;
            rdv_r  <= 1'b0;
            prst_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            byte_r <= byte_nxt;
            rs_r   <= rs_nxt;
            read_r <= read_nxt;
            word_r <= word_nxt;
            cs_n_r <= cs_n_nxt;
            wr_n_r <= wr_n_nxt;
            rd_n_r <= rd_n_nxt;
            d_r    <= d_nxt;
            oe_r   <= oe_nxt;
            rdv_r  <= rdv_nxt;
            prst_r <= 1'b1;
        end
    end

    assign link.cs_n        = cs_n_r;
    assign link.rs          = rs_r;
    assign link.wr_n        = wr_n_r;
    assign link.rd_n        = rd_n_r;
    assign link.host_d      = d_r;
    assign link.host_oe     = oe_r;
    assign link.panel_rst_n = prst_r;
    assign link.straps      = prst_r ? MODE_8BIT_STRAPS : MODE_8BIT_STRAPS;
    assign link.lower_lanes = LOWER_TIE;
    assign rd_valid_out     = rdv_r;
    assign rd_data_out      = word_r;
endmodule
`default_nettype wire

// ===== dv/tft_link_properties.sv
/* pin relations between the two ends of the byte-wide port.
   assumes it sits beside the interface, one clock, sync active low reset. */
`timescale 1ns/1ps
`default_nettype none
module tft_link_props
    import tft_port_pkg::*;
(
    input wire logic             core_clk_in,
    input wire logic             rstn_in,
    input wire logic             cs_n,
    input wire logic             wr_n,
    input wire logic             rd_n,
    input wire logic             host_oe,
    input wire logic             dev_oe,
    input wire logic [BUS_W-1:0] host_d
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);
    sequence s_low5(x); !x [*5]; endsequence
    sequence s_hi6(x); x [*6]; endsequence
    property p_one_drv; !(host_oe && dev_oe); endproperty
    a_one_drv: assert property (p_one_drv) else $error("bus driven twice");
    property p_wr_low; $fell(wr_n) |-> s_low5(wr_n); endproperty
    a_wr_low: assert property (p_wr_low) else $error("write strobe short");
    property p_wr_gap; $rose(wr_n) |-> s_hi6(wr_n); endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("write gap short");
    property p_rd_low; $fell(rd_n) |-> s_low5(rd_n) ##1 s_low5(rd_n); endproperty
    a_rd_low: assert property (p_rd_low) else $error("read strobe short");
    property p_rd_gap; $rose(rd_n) |-> s_hi6(rd_n); endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("read gap short");
    property p_cs; (!wr_n || !rd_n) |-> !cs_n; endproperty
    a_cs: assert property (p_cs) else $error("strobe without select");
    // allows the device seven cycles of filter lag before it lets go
    property p_dev_off; rd_n [*8] |-> !dev_oe; endproperty
    a_dev_off: assert property (p_dev_off) else $error("device drives late");
    property p_dev_on; $rose(dev_oe) |-> !rd_n && !cs_n; endproperty
    a_dev_on: assert property (p_dev_on) else $error("device drives unasked");
    property p_hold; !wr_n && !$past(wr_n) |-> host_oe && $stable(host_d); endproperty
    a_hold: assert property (p_hold) else $error("write data moved");
endmodule
`default_nettype wire

// ===== dv/test_tft_module_8bit_host_port.sv
/* bench joining host end and module end over one link.
   assumes both ends as designed; reads act as barriers for writes. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_tft_module_8bit_host_port;
    import tft_port_pkg::*;
    localparam logic [15:0] CODE = 16'h5A3C; // arbitrary value
    logic              core_clk_in = 1'b0;
    logic              rstn_in = 1'b0;
    logic              cmd_valid_in = 1'b0;
    logic              cmd_rs_in = 1'b0;
    logic              cmd_read_in = 1'b0;
    logic [WORD_W-1:0] cmd_data_in = 16'h0000;
    logic              cmd_ready_out;
    logic              rd_valid_out;
    logic              mode_ok_out;
    logic [WORD_W-1:0] rd_data_out;
    logic [WORD_W-1:0] rd;
    logic [IDX_W-1:0]  index_out;
    logic [ROW_W-1:0]  raster_row_out;
    logic [RED_W-1:0]  red_out;
    logic [GRN_W-1:0]  green_out;
    logic [BLU_W-1:0]  blue_out;
    logic [7:0]        bytes[$];
    int                mismatches = 0;
    int                tests_run = 0;
    always #25 core_clk_in = ~core_clk_in;
    tft_link_if link ();
    tft_host_end tft_host_end_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_rs_in(cmd_rs_in),
        .cmd_read_in(cmd_read_in), .cmd_data_in(cmd_data_in), .rd_valid_out(rd_valid_out),
        .rd_data_out(rd_data_out), .link(link.host));
    tft_module_end #(.DEVICE_CODE(CODE)) tft_module_end_i (.core_clk_in(core_clk_in),
        .rstn_in(rstn_in), .link(link.device), .raster_row_out(raster_row_out),
        .red_out(red_out), .green_out(green_out), .blue_out(blue_out),
        .index_out(index_out), .mode_ok_out(mode_ok_out));
    tft_link_props tft_link_props_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .cs_n(link.cs_n), .wr_n(link.wr_n), .rd_n(link.rd_n), .host_oe(link.host_oe),
        .dev_oe(link.dev_oe), .host_d(link.host_d));
    always @(posedge link.wr_n) if (!link.cs_n) bytes.push_back(link.bus);
    ////////////////////////////////////////////////////////////////////////
    task automatic cmd(input logic rs, input logic rdop, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge core_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_rs_in <= rs;
        cmd_read_in <= rdop;
        cmd_data_in <= d;
        do @(posedge core_clk_in); while (cmd_ready_out !== 1'b1 && ++n < 400);
        if (n >= 400) mismatches++;
        cmd_valid_in <= 1'b0;
    endtask
    task automatic rdw(input logic rs);
        int n;
        n = 0;
        cmd(rs, 1'b1, 16'h0000);
        do @(posedge core_clk_in); while (rd_valid_out !== 1'b1 && ++n < 400);
        if (n >= 400) mismatches++;
        rd = rd_data_out;
    endtask
    task automatic setr(input logic [6:0] idx, input logic [15:0] v);
        cmd(1'b0, 1'b0, {9'h000, idx});
        cmd(1'b1, 1'b0, v);
    endtask
    // two writes from start, then read back the last word of memory
    task automatic ram_pair(input logic [15:0] e, s, w1, w2);
        setr(IDX_ENTRY, e);
        setr(IDX_ADDR, s);
        cmd(1'b0, 1'b0, {9'h000, IDX_RAM});
        cmd(1'b1, 1'b0, w1);
        cmd(1'b1, 1'b0, w2);
        setr(IDX_ADDR, 16'(RAM_WORDS - 1));
        cmd(1'b0, 1'b0, {9'h000, IDX_RAM});
        rdw(1'b1);
    endtask
    task automatic t_index();
        bytes.delete();
        cmd(1'b0, 1'b0, {9'h000, IDX_RAM});
        rdw(1'b0);
        `CHK(mode_ok_out, 1'b1)
        `CHK(link.lower_lanes, LOWER_TIE)
        `CHK(index_out, IDX_RAM)
        `CHK(bytes[0], 8'h00)
        `CHK(bytes[1], {1'b0, IDX_RAM})
        `CHK(rd[7:0], 8'h00)
        `CHK(rd[15:8] < PANEL_ROWS, 1'b1)
    endtask
    task automatic t_code();
        cmd(1'b0, 1'b0, {9'h000, IDX_CODE});
        rdw(1'b1);
        `CHK(rd, CODE)
    endtask
    task automatic t_ram();
        ram_pair(16'h0000, 16'h0000, 16'hF800, 16'h07E0);
        `CHK(rd, 16'h07E0)
        ram_pair(ENTRY_RST, 16'(RAM_WORDS - 2), 16'h001F, 16'hF81F);
        `CHK(rd[GRN_LSB +: GRN_W], 6'h00)
        `CHK(rd, 16'hF81F)
    endtask
    task automatic t_fifo();
        @(posedge core_clk_in);
        cmd_valid_in <= 1'b1;
        cmd_rs_in <= 1'b0;
        cmd_read_in <= 1'b0;
        cmd_data_in <= {9'h000, IDX_ENTRY};
        repeat (8) @(posedge core_clk_in);
        `CHK(cmd_ready_out, 1'b0)
        cmd_valid_in <= 1'b0;
        rdw(1'b0);
        `CHK(index_out, IDX_ENTRY)
    endtask
    // row zero starts with memory word zero, written red earlier
    task automatic t_scan();
        int n;
        n = 0;
        do @(posedge core_clk_in); while (raster_row_out != 8'(PANEL_ROWS - 1) && ++n < 30000);
        do @(posedge core_clk_in); while (raster_row_out != 8'h00 && ++n < 30000);
        if (n >= 30000) mismatches++;
        `CHK({red_out, green_out, blue_out}, 16'hF800)
    endtask
    task automatic t_reset();
        @(posedge core_clk_in);
        rstn_in <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        `CHK(index_out, 7'h00)
        `CHK(link.panel_rst_n, 1'b0)
        rstn_in <= 1'b1;
        rdw(1'b0);
        `CHK(mode_ok_out, 1'b1)
    endtask
    task automatic complete_run();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        t_index();
        t_code();
        t_ram();
        t_fifo();
        t_scan();
        t_reset();
        complete_run();
    end
    // about two and a half times the expected run, most of it one scan frame
    initial begin
        #2500000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
